// ---- src/telegram_consts.svh ----
// Constants for the telegram master: byte values, lengths, field offsets.
// Assumes inclusion by the design modules and the testbench files by bare name.
`ifndef TELEGRAM_CONSTS_SVH
`define TELEGRAM_CONSTS_SVH

// Character framing.
`define CHAR_BITS 4'hb
`define CHAR_DATA_BITS 4'h8
`define CHAR_START_LEVEL 1'b0
`define CHAR_STOP_LEVEL 1'b1

// Telegram bytes and lengths.
`define TELEGRAM_START_BYTE 8'h02
`define LENGTH_SHORT 8'h06
`define LENGTH_LONG 8'h0e
`define LENGTH_TEXT_FIXED 8'h0a
`define LENGTH_OUTSIDE 8'h02
`define HEADER_BYTES 8'h03

// Field offsets inside the data area.
`define OFS_IND 8'h02
`define OFS_PWE 8'h04
`define OFS_PCD_LONG 8'h08
`define OFS_TEXT 8'h04

// Address byte layout.
`define ADR_FORMAT_BIT 7
`define ADR_BCAST_BIT 5
`define ADR_LOW7_ZERO 7'h00

// Response code of a command that could not be performed.
`define RESP_NOT_PERFORMED 4'h7

`endif

// ---- src/telegram_pkg.sv ----
// Types shared by the telegram master, its checker and its testbench.
// Assumes telegram_consts.svh is on the include path.
package telegram_pkg;
  typedef enum logic [1:0] {
    FMT_SHORT = 2'b00,
    FMT_LONG = 2'b01,
    FMT_TEXT = 2'b10
  } fmt_e;

  typedef enum logic [2:0] {
    ST_OK = 3'b000,
    ST_BCAST = 3'b001,
    ST_TIMEOUT = 3'b010,
    ST_PARITY = 3'b011,
    ST_CHECK = 3'b100,
    ST_FORMAT = 3'b101,
    ST_FAILED = 3'b110
  } status_e;

  // One request: address, format, parameter channel and process block.
  typedef struct packed {
    logic [7:0] address;
    fmt_e fmt;
    logic [15:0] parameter_key_word;
    logic [15:0] subscript_field;
    logic [31:0] parameter_value_field;
    logic [31:0] process_block;
    logic [7:0] text_len;
  } req_s;

  // Fields of an accepted reply.
  typedef struct packed {
    logic [15:0] parameter_key_word;
    logic [15:0] subscript_field;
    logic [31:0] parameter_value_field;
    logic [31:0] process_block;
  } rep_s;
endpackage

// ---- src/char_tx.sv ----
// Serial character sender: start, eight data bits, even parity, stop.
// Assumes one clock; baud_div holds system clocks per bit period.
`timescale 1ns/1ps
`default_nettype none
`include "telegram_consts.svh"
module char_tx (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Bit period in clocks.
  input wire logic [15:0] baud_div,
  // Byte handshake.
  input wire logic [7:0] data,
  input wire logic valid,
  output logic ready,
  // Line.
  output logic line
);
  logic [10:0] shreg;
  logic [3:0] left;
  logic [15:0] div;

  // Ready is combinational so the master can chain bytes with only one idle clock between them.
  assign ready = (left == 4'h0);
  assign line = shreg[0];

  // Shift one bit per bit period, least significant data bit first.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shreg <= {11{`CHAR_STOP_LEVEL}};
      left <= 4'h0;
      div <= 16'h0000;
    end else if (ready) begin
      if (valid) begin
        // Parity makes data plus parity carry an even count of ones.
        shreg <= {`CHAR_STOP_LEVEL, ^data, data, `CHAR_START_LEVEL};
        left <= `CHAR_BITS;
        div <= baud_div - 16'h0001;
      end
    end else if (div == 16'h0000) begin
      shreg <= {`CHAR_STOP_LEVEL, shreg[10:1]};
      left <= left - 4'h1;
      div <= baud_div - 16'h0001;
    end else begin
      div <= div - 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- src/char_rx.sv ----
// Serial character receiver with parity and stop-bit checks.
// Assumes the line input is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "telegram_consts.svh"
module char_rx (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Bit period in clocks and receive enable.
  input wire logic [15:0] baud_div,
  input wire logic enable,
  // Line.
  input wire logic line,
  // Received byte.
  output logic [7:0] data,
  output logic valid,
  output logic bad
);
  logic busy;
  logic [3:0] nbits;
  logic [15:0] div;
  logic [10:0] shreg;

  // Sample at mid-bit: first wait half a period after the falling edge.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy <= 1'b0;
      nbits <= 4'h0;
      div <= 16'h0000;
      shreg <= 11'h000;
    end else if (!busy) begin
      if (enable && line == `CHAR_START_LEVEL) begin
        busy <= 1'b1;
        nbits <= 4'h0;
        div <= {1'b0, baud_div[15:1]};
      end
    end else if (div == 16'h0000) begin
      shreg <= {line, shreg[10:1]};
      nbits <= nbits + 4'h1;
      div <= baud_div - 16'h0001;
      if (nbits == `CHAR_BITS - 4'h1) begin
        busy <= 1'b0;
      end
    end else begin
      div <= div - 16'h0001;
    end
  end

  // Deliver the byte with a flag for bad parity, start or stop.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data <= 8'h00;
      valid <= 1'b0;
      bad <= 1'b0;
    end else begin
      valid <= busy && div == 16'h0000 && nbits == `CHAR_BITS - 4'h1;
      if (busy && div == 16'h0000 && nbits == `CHAR_BITS - 4'h1) begin
        data <= shreg[9:2];
        bad <= (^shreg[10:2]) || line != `CHAR_STOP_LEVEL ||
               shreg[1] != `CHAR_START_LEVEL;
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/telegram_master.sv ----
// Bus master for the drive's serial telegram port: builds a request
// telegram, sends it half-duplex, then collects and checks the reply.
// Assumes one 40 MHz clock and a line receiver synchronous to it.
//
// What this block does
// - Characters are start, eight data, parity, stop: eleven bits.
// - Parity bit makes data plus parity hold an even count of ones.
// - Address 1-126, baud 2400-115200, even parity one stop bit.
// - Every telegram begins with start byte 0x02.
// - Start, length, address, data bytes, then one check byte.
// - Length is data bytes plus two: 6 short, 14 long.
// - Text telegram length is ten fixed bytes plus text bytes.
// - Check byte is XOR of all telegram bytes from zero.
// - One permanent master addresses up to 126 followers.
// - Formats: 8-byte process, 16-byte parameter, variable text.
// - Process block is four bytes: control/reference or status/speed.
// - Parameter data block is twelve bytes including process block.
// - Key word bits 12-15 carry command or response code.
// - Key word bits 0-11 carry the parameter number.
// - Value field is four bytes: written value or read value.
// - Text uses command 0xF, subscript high byte 4 read, 5 write.
`timescale 1ns/1ps
`default_nettype none
`include "telegram_consts.svh"
module telegram_master
  import telegram_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Configuration, all in system clocks.
  input wire logic [15:0] baud_div,
  input wire logic [23:0] max_resp_cycles,
  input wire logic [23:0] max_gap_cycles,
  // Request.
  input wire logic req_valid,
  output logic req_ready,
  input wire req_s req,
  // Outgoing text bytes.
  input wire logic [7:0] text_tx_data,
  input wire logic text_tx_valid,
  output logic text_tx_ready,
  // Result.
  output logic done,
  output status_e status,
  output rep_s reply,
  output logic [7:0] rx_text_data,
  output logic rx_text_valid,
  // Bus line.
  output logic bus_tx,
  output logic bus_tx_oe,
  input wire logic bus_rx
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SEND = 2'b01,
    S_WAIT = 2'b10
  } state_e;

  state_e state;
  req_s cur;
  logic [7:0] length_byte;
  logic [7:0] tx_idx;
  logic [7:0] tx_bcc;
  logic [7:0] tx_byte;
  logic tx_is_text;
  logic tx_go;
  logic tx_ready;
  logic [7:0] rx_idx;
  logic [7:0] rx_lge;
  logic [7:0] rx_bcc;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_bad;
  logic [23:0] tmr;
  logic is_bcast;
  logic [7:0] k;
  logic [7:0] rk;
  logic finish;
  status_e next_status;

  // Pick byte j of a 32-bit field, most significant first.
  function automatic logic [7:0] pick32(input logic [31:0] w,
                                        input logic [1:0] j);
    logic [7:0] b;
    b = 8'h00;
    unique case (j)
      2'b00: b = w[31:24];
      2'b01: b = w[23:16];
      2'b10: b = w[15:8];
      2'b11: b = w[7:0];
    endcase
    return b;
  endfunction

  // Broadcast in either address format needs no reply.
  assign is_bcast = cur.address[`ADR_FORMAT_BIT] ?
                    (cur.address[6:0] == `ADR_LOW7_ZERO) :
                    cur.address[`ADR_BCAST_BIT];

  // Length byte per format.
  always_comb begin
    length_byte = `LENGTH_SHORT;
    unique case (cur.fmt)
      FMT_SHORT: length_byte = `LENGTH_SHORT;
      FMT_LONG: length_byte = `LENGTH_LONG;
      FMT_TEXT: length_byte = `LENGTH_TEXT_FIXED + cur.text_len;
      default: length_byte = `LENGTH_SHORT;
    endcase
  end

  // Byte to send at tx_idx; k is the offset inside the data area.
  always_comb begin
    k = tx_idx - `HEADER_BYTES;
    tx_byte = 8'h00;
    tx_is_text = 1'b0;
    if (tx_idx == 8'h00) begin
      tx_byte = `TELEGRAM_START_BYTE;
    end else if (tx_idx == 8'h01) begin
      tx_byte = length_byte;
    end else if (tx_idx == 8'h02) begin
      tx_byte = cur.address;
    end else if (tx_idx == length_byte + 8'h01) begin
      tx_byte = tx_bcc;
    end else if (cur.fmt == FMT_SHORT) begin
      tx_byte = pick32(cur.process_block, k[1:0]);
    end else if (k < `OFS_IND) begin
      // Command in bits 12-15, parameter number in 0-11.
      tx_byte = k[0] ? cur.parameter_key_word[7:0] :
                cur.parameter_key_word[15:8];
    end else if (k < `OFS_PWE) begin
      // For text the high subscript byte selects read or write.
      tx_byte = k[0] ? cur.subscript_field[7:0] :
                cur.subscript_field[15:8];
    end else if (cur.fmt == FMT_LONG) begin
      // Value then process block make up the last eight of the twelve bytes.
      tx_byte = (k < `OFS_PCD_LONG) ?
                pick32(cur.parameter_value_field, k[1:0]) :
                pick32(cur.process_block, k[1:0]);
    end else if (k < `OFS_TEXT + cur.text_len) begin
      tx_byte = text_tx_data;
      tx_is_text = 1'b1;
    end else begin
      tx_byte = pick32(cur.process_block,
                       2'(k - `OFS_TEXT - cur.text_len));
    end
  end

  // A text byte goes out only when the source offers one.
  assign tx_go = (state == S_SEND) && tx_ready &&
                 (!tx_is_text || text_tx_valid);
  assign text_tx_ready = (state == S_SEND) && tx_ready && tx_is_text;
  assign req_ready = (state == S_IDLE);
  // Drive the line only while sending; release it for the reply.
  assign bus_tx_oe = (state == S_SEND) || !tx_ready;

  // Main sequence: idle, send telegram, wait for the reply.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= S_IDLE;
      cur <= '0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (req_valid) begin
            cur <= req;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          // State moves on as soon as the check byte is handed to the sender, while it still drains.
          if (tx_go && tx_idx == length_byte + 8'h01) begin
            state <= is_bcast ? S_IDLE : S_WAIT;
          end
        end
        S_WAIT: begin
          if (finish) begin
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Transmit index and running check byte, cleared per telegram.
  always_ff @(posedge sys_clk) begin
    if (srst || state == S_IDLE) begin
      tx_idx <= 8'h00;
      tx_bcc <= 8'h00;
    end else if (tx_go) begin
      tx_idx <= tx_idx + 8'h01;
      tx_bcc <= tx_bcc ^ tx_byte;
    end
  end

  // Reply timer: response window before the first byte, then byte gap.
  // It starts once the request has fully left, so the follower's minimum
  // turnaround delay falls inside the window.
  always_ff @(posedge sys_clk) begin
    if (srst || state != S_WAIT || !tx_ready || rx_valid) begin
      tmr <= 24'h000000;
    end else begin
      tmr <= tmr + 24'h000001;
    end
  end

  assign rk = rx_idx - `HEADER_BYTES;

  // Judge each reply byte; the first fault ends the wait.
  always_comb begin
    finish = 1'b0;
    next_status = ST_OK;
    if (state == S_WAIT) begin
      if (!rx_valid) begin
        if (rx_idx == 8'h00 && tmr >= max_resp_cycles) begin
          finish = 1'b1;
          next_status = ST_TIMEOUT;
        end else if (rx_idx != 8'h00 && tmr >= max_gap_cycles) begin
          finish = 1'b1;
          next_status = ST_TIMEOUT;
        end
      end else if (rx_bad) begin
        finish = 1'b1;
        next_status = ST_PARITY;
      end else if (rx_idx == 8'h00) begin
        finish = (rx_data != `TELEGRAM_START_BYTE);
        next_status = ST_FORMAT;
      end else if (rx_idx == 8'h01) begin
        // Same type as the request: exact length, or text.
        finish = (cur.fmt == FMT_TEXT) ? (rx_data < `LENGTH_TEXT_FIXED) :
                 (rx_data != length_byte);
        next_status = ST_FORMAT;
      end else if (rx_idx == 8'h02) begin
        finish = (rx_data != cur.address);
        next_status = ST_FORMAT;
      end else if (rx_idx == rx_lge + 8'h01) begin
        finish = 1'b1;
        if (rx_bcc != rx_data) begin
          next_status = ST_CHECK;
        end else if (reply.parameter_key_word[15:12] ==
                     `RESP_NOT_PERFORMED && cur.fmt != FMT_SHORT) begin
          next_status = ST_FAILED;
        end else begin
          next_status = ST_OK;
        end
      end
    end
  end

  // Receive index, length and check accumulator.
  always_ff @(posedge sys_clk) begin
    if (srst || state != S_WAIT) begin
      rx_idx <= 8'h00;
      rx_lge <= 8'h00;
      rx_bcc <= 8'h00;
    end else if (rx_valid) begin
      rx_idx <= rx_idx + 8'h01;
      rx_bcc <= rx_bcc ^ rx_data;
      if (rx_idx == 8'h01) begin
        rx_lge <= rx_data;
      end
    end
  end

  // Shift reply data bytes into their fields, same layout as sending.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reply <= '0;
    end else if (state == S_IDLE && req_valid) begin
      reply <= '0;
    end else if (state == S_WAIT && rx_valid && !rx_bad &&
                 rx_idx > 8'h02 && rx_idx <= rx_lge) begin
      if (cur.fmt == FMT_SHORT || (cur.fmt == FMT_LONG &&
          rk >= `OFS_PCD_LONG) || (cur.fmt == FMT_TEXT &&
          rk >= rx_lge - `LENGTH_TEXT_FIXED + `OFS_TEXT)) begin
        reply.process_block <= {reply.process_block[23:0], rx_data};
      end else if (rk < `OFS_IND) begin
        reply.parameter_key_word <= {reply.parameter_key_word[7:0],
                                     rx_data};
      end else if (rk < `OFS_PWE) begin
        reply.subscript_field <= {reply.subscript_field[7:0], rx_data};
      end else if (cur.fmt == FMT_LONG) begin
        reply.parameter_value_field <=
          {reply.parameter_value_field[23:0], rx_data};
      end
    end
  end

  // Text bytes of a reply stream straight out, one pulse each.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_text_data <= 8'h00;
      rx_text_valid <= 1'b0;
    end else begin
      rx_text_valid <= 1'b0;
      if (state == S_WAIT && rx_valid && !rx_bad && cur.fmt == FMT_TEXT &&
          rx_idx > 8'h02 && rk >= `OFS_TEXT &&
          rk < rx_lge - `LENGTH_TEXT_FIXED + `OFS_TEXT) begin
        rx_text_data <= rx_data;
        rx_text_valid <= 1'b1;
      end
    end
  end

  // Completion pulse and held status; broadcasts end without a reply.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      done <= 1'b0;
      status <= ST_OK;
    end else begin
      done <= 1'b0;
      if (state == S_SEND && tx_go && tx_idx == length_byte + 8'h01 && is_bcast) begin
        done <= 1'b1;
        status <= ST_BCAST;
      end else if (finish) begin
        done <= 1'b1;
        status <= next_status;
      end
    end
  end

  char_tx u_tx (
    .sys_clk(sys_clk),
    .srst(srst),
    .baud_div(baud_div),
    .data(tx_byte),
    .valid(tx_go),
    .ready(tx_ready),
    .line(bus_tx)
  );

  char_rx u_rx (
    .sys_clk(sys_clk),
    .srst(srst),
    .baud_div(baud_div),
    .enable(state == S_WAIT && tx_ready), // Deaf while sending.
    .line(bus_rx),
    .data(rx_data),
    .valid(rx_valid),
    .bad(rx_bad)
  );
endmodule
`default_nettype wire

// ---- testbench/telegram_master_sva.sv ----
// Checker for the telegram master: line framing and result relations.
// Assumes it is bound to telegram_master and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "telegram_consts.svh"
module telegram_master_sva
  import telegram_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Request side and result.
  input wire logic [15:0] baud_div,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic done,
  input wire status_e status,
  input wire rep_s reply,
  // Bus line.
  input wire logic bus_tx,
  input wire logic bus_tx_oe
);
  logic [31:0] cyc;
  logic [31:0] bitpos;
  logic [31:0] phase;
  logic in_char;
  logic active;
  logic first;
  logic par;
  logic [10:0] stx_frame;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Position inside the character that began at the last low start bit.
  // The sender may idle between characters, so the grid restarts each time.
  always_comb begin
    active = in_char || (bus_tx_oe && !bus_tx);
    bitpos = in_char ? cyc / baud_div : 32'h0;
    phase = in_char ? cyc % baud_div : 32'h0;
    stx_frame = {1'b1, ^`TELEGRAM_START_BYTE, `TELEGRAM_START_BYTE, 1'b0};
  end

  // Cycle count of the character on the line, eleven bit periods long.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      in_char <= 1'b0;
      cyc <= 32'h0;
    end else if (!in_char) begin
      in_char <= bus_tx_oe && !bus_tx;
      cyc <= 32'h1;
    end else if (cyc == 11 * baud_div - 1) begin
      in_char <= 1'b0;
    end else begin
      cyc <= cyc + 32'h1;
    end
  end

  // The first character after the driver comes on is the start byte.
  always_ff @(posedge sys_clk) begin
    if (srst || !bus_tx_oe) begin
      first <= 1'b1;
    end else if (in_char && cyc == 11 * baud_div - 1) begin
      first <= 1'b0;
    end
  end

  // Parity of the data bits seen so far in this character.
  always_ff @(posedge sys_clk) begin
    if (srst || bitpos == 32'h0) begin
      par <= 1'b0;
    end else if (phase == 32'h0 && bitpos < 32'h9) begin
      par <= par ^ bus_tx;
    end
  end

  a_stx_frame: assert property (active && first
    |-> bus_tx == stx_frame[bitpos[3:0]]) else $error("Start byte wrong.");
  a_start_bit: assert property (active && bitpos == 0 |-> !bus_tx)
    else $error("Start bit not low.");
  a_stop_bit: assert property (active && bitpos == 10 |-> bus_tx)
    else $error("Stop bit not high.");
  a_even_parity: assert property (active && bitpos == 9
    |-> bus_tx == par) else $error("Parity bit not even.");
  a_whole_chars: assert property ($fell(bus_tx_oe) |-> !in_char)
    else $error("Driver off mid-char.");
  a_first_bit: assert property (req_valid && req_ready && !bus_tx_oe
    |=> bus_tx_oe ##1 (bus_tx_oe && !bus_tx))
    else $error("Telegram did not start.");
  a_listen_quiet: assert property (!bus_tx_oe && !req_ready
    |=> !bus_tx_oe) else $error("Driver on while listening.");
  a_bcast_early: assert property (done && status == ST_BCAST
    |-> bus_tx_oe) else $error("Broadcast waited for a reply.");
  a_fail_code: assert property (done && status == ST_FAILED
    |-> reply.parameter_key_word[15:12] == `RESP_NOT_PERFORMED)
    else $error("Failed status without code 7.");
  a_done_pulse: assert property (done |=> !done)
    else $error("Done longer than one cycle.");

  c_ok: cover property (done && status == ST_OK);
  c_bcast: cover property (done && status == ST_BCAST);
  c_failed: cover property (done && status == ST_FAILED);
endmodule

bind telegram_master telegram_master_sva u_telegram_master_sva (
  .sys_clk(sys_clk), .srst(srst), .baud_div(baud_div),
  .req_valid(req_valid), .req_ready(req_ready), .done(done),
  .status(status), .reply(reply), .bus_tx(bus_tx), .bus_tx_oe(bus_tx_oe)
);
`default_nettype wire

// ---- testbench/follower_model.sv ----
// Follower model: one drive node that checks requests and answers them.
// Assumes BAUD clocks per bit and a released line that reads high.
`timescale 1ns/1ps
`default_nettype none
`include "telegram_consts.svh"
module follower_model #(
  parameter int BAUD = 8,
  parameter logic [7:0] OWN_ADDRESS = 8'h85,
  parameter logic [11:0] KNOWN_PARAM = 12'h19e,
  parameter logic [31:0] STATUS_WORDS = 32'h0b07_1234,
  parameter int REPLY_DELAY = 20
) (
  // Clock.
  input wire logic sys_clk,
  // Line from the master and a request to spoil the check byte.
  input wire logic line_in,
  input wire logic corrupt,
  // Line towards the master.
  output logic line_out
);
  logic [7:0] rx [0:31];
  logic [7:0] b, len, acc;
  logic ok, ok1, bcast;
  logic [3:0] cmd, resp;
  logic [15:0] stored;
  logic [103:0] pay;

  // Samples one character mid-bit; good drops on parity or stop faults.
  task automatic get_byte(output logic [7:0] d, output logic good);
    logic p;
    @(negedge line_in);
    repeat (BAUD / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD) @(posedge sys_clk);
      d[i] = line_in;
    end
    repeat (BAUD) @(posedge sys_clk);
    p = line_in;
    repeat (BAUD) @(posedge sys_clk);
    good = line_in && ((^d) == p);
  endtask

  // Sends one character, LSB first, changing just after a clock edge.
  task automatic put_byte(input logic [7:0] d);
    logic [10:0] frame;
    frame = {1'b1, ^d, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= frame[i];
      repeat (BAUD) @(posedge sys_clk);
    end
  endtask

  // Request parsing, execution and reply; silence on any framing or check-byte fault.
  initial begin
    line_out = 1'b1;
    stored = 16'h0000;
    forever begin
      get_byte(b, ok);
      if (b != `TELEGRAM_START_BYTE) continue;
      get_byte(len, ok1);
      ok = ok & ok1;
      acc = b ^ len;
      for (int i = 0; i < len; i++) begin
        get_byte(rx[i], ok1);
        ok = ok & ok1;
        acc = acc ^ rx[i];
      end
      bcast = rx[0][7] ? (rx[0][6:0] == 7'h00) : rx[0][5];
      if (!ok || acc != 8'h00) continue;
      if (!bcast && rx[0] != OWN_ADDRESS) continue;
      cmd = rx[1][7:4];
      case (cmd)
        4'h1, 4'h2, 4'he: resp = 4'h1;
        4'h3, 4'hd: resp = 4'h2;
        default: resp = 4'h0;
      endcase
      if ({rx[1][3:0], rx[2]} != KNOWN_PARAM) begin
        resp = 4'h7;
      end else if (cmd inside {4'h2, 4'h3, 4'hd, 4'he}) begin
        stored = {rx[7], rx[8]};
      end
      if (bcast) continue;
      repeat (REPLY_DELAY) @(posedge sys_clk);
      pay = {rx[0], STATUS_WORDS, 64'h0};
      if (len == `LENGTH_LONG) begin
        pay = {rx[0], resp, rx[1][3:0], rx[2], rx[3], rx[4],
               resp == 4'h7 ? 32'h0 : {16'h0, stored}, STATUS_WORDS};
      end
      put_byte(`TELEGRAM_START_BYTE);
      put_byte(len);
      acc = `TELEGRAM_START_BYTE ^ len;
      for (int k = 0; k < len - 1; k++) begin
        acc = acc ^ pay[103 - 8 * k -: 8];
        put_byte(pay[103 - 8 * k -: 8]);
      end
      put_byte(corrupt ? ~acc : acc);
    end
  end
endmodule
`default_nettype wire

// ---- testbench/telegram_master_test.sv ----
// Testbench for the telegram master against one follower model.
// Assumes the design, the checker and the follower model are compiled.
`timescale 1ns/1ps
`default_nettype none
module telegram_master_test
  import telegram_pkg::*;
;
  localparam logic [31:0] STATUS_EXP = 32'h0b07_1234;
  logic sys_clk, srst, req_valid, req_ready, done, bus_tx, bus_tx_oe;
  logic bus_rx, line_in, corrupt, text_tx_valid;
  logic [15:0] baud_div;
  logic [23:0] max_resp_cycles, max_gap_cycles;
  logic [7:0] text_tx_data;
  req_s req;
  status_e status;
  rep_s reply;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  // A released master line reads high through the bus bias.
  assign line_in = bus_tx_oe ? bus_tx : 1'b1;

  telegram_master u_telegram_master (
    .sys_clk(sys_clk), .srst(srst), .baud_div(baud_div),
    .max_resp_cycles(max_resp_cycles), .max_gap_cycles(max_gap_cycles),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .text_tx_data(text_tx_data), .text_tx_valid(text_tx_valid),
    .text_tx_ready(), .done(done), .status(status), .reply(reply),
    .rx_text_data(), .rx_text_valid(), .bus_tx(bus_tx),
    .bus_tx_oe(bus_tx_oe), .bus_rx(bus_rx)
  );

  follower_model #(.BAUD(8), .STATUS_WORDS(STATUS_EXP)) u_follower_model (
    .sys_clk(sys_clk), .line_in(line_in), .corrupt(corrupt),
    .line_out(bus_rx)
  );

  // Clock of 25 ns and a ceiling well above the expected run length.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_st(input status_e exp);
    check_count++;
    if (status !== exp) begin
      fails++;
      $display("MISMATCH %0t status %0d not %0d", $time, status, exp);
    end
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t value %h not %h", $time, got, exp);
    end
  endtask

  function automatic req_s mk(input logic [7:0] a, input fmt_e f,
                              input logic [15:0] k, input logic [31:0] v);
    return '{address: a, fmt: f, parameter_key_word: k, subscript_field: 16'h0,
             parameter_value_field: v, process_block: 32'h047c_2000,
             text_len: 8'h0};
  endfunction

  // Offers one request at a falling edge and waits for its done pulse.
  task automatic run_req(input req_s r);
    int n;
    @(negedge sys_clk);
    req = r;
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp_val({31'h0, done}, 32'h1);
  endtask

  task automatic t_short();
    run_req(mk(8'h85, FMT_SHORT, 16'h0, 32'h0));
    cmp_st(ST_OK);
    cmp_val(reply.process_block, STATUS_EXP);
  endtask

  // Every write command, each read back at once by the next request.
  task automatic t_write_read();
    logic [3:0] cmds [4] = '{4'h2, 4'h3, 4'hd, 4'he};
    logic [3:0] resp [4] = '{4'h1, 4'h2, 4'h2, 4'h1};
    for (int i = 0; i < 4; i++) begin
      run_req(mk(8'h85, FMT_LONG, {cmds[i], 12'h19e}, {28'h20, cmds[i]}));
      cmp_val({28'h0, reply.parameter_key_word[15:12]}, resp[i]);
      run_req(mk(8'h85, FMT_LONG, 16'h119e, 32'h0));
      cmp_val(reply.parameter_value_field, {28'h20, cmds[i]});
      cmp_val({20'h0, reply.parameter_key_word[11:0]}, 32'h19e);
    end
    run_req(mk(8'h85, FMT_LONG, 16'h019e, 32'h0));
    cmp_val({28'h0, reply.parameter_key_word[15:12]}, 32'h0);
  endtask

  task automatic t_fault();
    run_req(mk(8'h85, FMT_LONG, 16'h2123, 32'h5));
    cmp_st(ST_FAILED);
    cmp_val({16'h0, reply.parameter_value_field[15:0]}, 32'h0);
  endtask

  // Both broadcast forms are executed but never answered.
  task automatic t_bcast();
    logic [7:0] adr [2] = '{8'h25, 8'h80};
    for (int i = 0; i < 2; i++) begin
      run_req(mk(adr[i], FMT_LONG, 16'h219e, 32'h0aa0 + i));
      cmp_st(ST_BCAST);
      run_req(mk(8'h85, FMT_LONG, 16'h119e, 32'h0));
      cmp_val(reply.parameter_value_field, 32'h0aa0 + i);
    end
  endtask

  task automatic t_foreign();
    run_req(mk(8'h86, FMT_SHORT, 16'h0, 32'h0));
    cmp_st(ST_TIMEOUT);
    run_req(mk(8'h06, FMT_LONG, 16'h119e, 32'h0));
    cmp_st(ST_TIMEOUT);
  endtask

  task automatic t_corrupt();
    @(negedge sys_clk);
    corrupt = 1'b1;
    run_req(mk(8'h85, FMT_SHORT, 16'h0, 32'h0));
    cmp_st(ST_CHECK);
    corrupt = 1'b0;
  endtask

  initial begin
    srst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    corrupt = 1'b0;
    baud_div = 16'h0008;
    max_resp_cycles = 24'h000190;
    max_gap_cycles = 24'h0000c8;
    text_tx_data = 8'h00;
    text_tx_valid = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    t_short();
    t_write_read();
    t_fault();
    t_bcast();
    t_foreign();
    t_corrupt();
    stop_test();
  end
endmodule
`default_nettype wire
